// ---- i2c_register_access_slave_bench.sv ----
// self-checking bench: host and device ends joined by the bus
`timescale 1ns/1ps

module i2c_register_access_slave_bench;
  typedef struct packed {
    logic            rd;
    logic [6:0]      dev;
    logic [7:0]      rg;
    logic [7:0]      len;
    logic [1:0][7:0] d;
    logic            nk;
    logic            sel;
  } ira_row_type;

  logic        ref_clk;
  logic        rstn;
  logic        strap_lvl;
  logic        cmd_valid;
  logic        cmd_rd;
  logic [6:0]  cmd_dev;
  logic [7:0]  cmd_reg;
  logic [7:0]  cmd_len;
  logic [7:0]  wr_data;
  logic        cmd_ready;
  logic        wr_take;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic        done;
  logic        nack;
  logic        busy;
  logic        upd_valid;
  logic [7:0]  upd_addr;
  logic [7:0]  upd_data;
  logic [8:0]  mon_sh;
  logic [8:0]  mon_first;
  logic [8:0]  mon_last;
  int          mon_bits = 0;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  ira_row_type rows [4];

  ira_bus_if ira_bus_if_inst ();
  ira_host ira_host_inst (.bus(ira_bus_if_inst), .ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_rd(cmd_rd), .cmd_dev(cmd_dev), .cmd_reg(cmd_reg), .cmd_len(cmd_len), .wr_data(wr_data),
    .cmd_ready(cmd_ready), .wr_take(wr_take), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
  // strap comes from each row, so both address settings are exercised
  ira_dev ira_dev_inst (.bus(ira_bus_if_inst), .ref_clk(ref_clk), .rstn(rstn), .io_supply_level(strap_lvl),
    .busy(busy), .upd_valid(upd_valid), .upd_addr(upd_addr), .upd_data(upd_data));
  ira_bus_assertions ira_bus_assertions_inst (.ref_clk(ref_clk), .rstn(rstn),
    .scl_h_oe(ira_bus_if_inst.scl_h_oe), .scl_h_out(ira_bus_if_inst.scl_h_out),
    .sda_h_oe(ira_bus_if_inst.sda_h_oe), .sda_h_out(ira_bus_if_inst.sda_h_out),
    .sda_d_oe(ira_bus_if_inst.sda_d_oe), .sda_d_out(ira_bus_if_inst.sda_d_out),
    .scl(ira_bus_if_inst.scl), .sda(ira_bus_if_inst.sda));

  // ---------------------------------------------------------
  // clock, timeout and wire monitor
  // ---------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 98000) begin
      n_errors++;
      end_sim();
    end
  end

  // slot counter restarts at every start, so mon_first is the last address slot
  always @(negedge ira_bus_if_inst.sda) begin
    if (ira_bus_if_inst.scl === 1'b1) begin
      mon_bits = 0;
    end
  end

  always @(posedge ira_bus_if_inst.scl) begin
    mon_sh = {mon_sh[7:0], ira_bus_if_inst.sda};
    mon_bits++;
    if (mon_bits == 9) begin
      mon_first = mon_sh;
    end
    if (mon_bits % 9 == 0) begin
      mon_last = mon_sh;
    end
  end

  // ---------------------------------------------------------
  // tasks
  // ---------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic send_cmd(input logic rd, input logic [6:0] dev, input logic [7:0] rg, input logic [7:0] len);
    cmd_rd = rd;
    cmd_dev = dev;
    cmd_reg = rg;
    cmd_len = len;
    cmd_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
  endtask

  task automatic run_row(input ira_row_type r);
    int   n;
    int   ri;
    int   ui;
    logic take_p;
    n = 0;
    ri = 0;
    ui = 0;
    take_p = 1'b0;
    wr_data = r.d[0];
    strap_lvl = r.sel;
    send_cmd(r.rd, r.dev, r.rg, r.len);
    while (done !== 1'b1 && n < 60000) begin
      @(posedge ref_clk);
      #1;
      n++;
      // rows hold at most two bytes, so the second one stays up after any take
      if (take_p) begin
        wr_data = r.d[1];
      end
      take_p = (wr_take === 1'b1);
      if (wr_take === 1'b1) begin
        check(busy, 1'b1);
      end
      if (rd_valid === 1'b1) begin
        check(rd_data, r.d[ri[0]]);
        ri++;
      end
      if (upd_valid === 1'b1) begin
        check(upd_addr, 8'(r.rg + ui));
        check(upd_data, r.d[ui[0]]);
        ui++;
      end
    end
    check(8'(ri), r.rd ? r.len : 8'h00);
    check(8'(ui), r.rd ? 8'h00 : r.len);
    check(nack, r.nk);
    check(mon_first, {r.dev, r.rd, r.nk});
    if (r.len != 8'h00) begin
      check(mon_last, {r.d[r.len - 8'h01], r.rd});
    end
    repeat (8) @(posedge ref_clk);
    #1;
    check(busy, 1'b0);
  endtask

  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial begin
    rstn = 1'b0;
    strap_lvl = 1'b1;
    cmd_valid = 1'b0;
    cmd_rd = 1'b0;
    cmd_dev = 7'h00;
    cmd_reg = 8'h00;
    cmd_len = 8'h00;
    wr_data = 8'h00;
    // wrap at the top register, then read it back across a repeated start; row 2 uses the low strap
    rows[0] = '{1'b0, 7'h41, 8'hff, 8'h02, 16'h3ca5, 1'b0, 1'b1};
    rows[1] = '{1'b1, 7'h41, 8'hff, 8'h02, 16'h3ca5, 1'b0, 1'b1};
    rows[2] = '{1'b1, 7'h40, 8'h00, 8'h01, 16'h003c, 1'b0, 1'b0};
    rows[3] = '{1'b0, 7'h40, 8'h10, 8'h00, 16'h0000, 1'b1, 1'b1};
    repeat (10) @(posedge ref_clk);
    #1;
    check({ira_bus_if_inst.scl, ira_bus_if_inst.sda, cmd_ready, busy}, 4'b1110);
    rstn = 1'b1;
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    // reset in mid-frame must release both wires and leave both ends idle
    send_cmd(1'b0, 7'h41, 8'h20, 8'h01);
    repeat (3000) @(posedge ref_clk);
    #1;
    rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check({ira_bus_if_inst.scl, ira_bus_if_inst.sda, cmd_ready, busy, done}, 5'b11100);
    rstn = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check({ira_bus_if_inst.scl, ira_bus_if_inst.sda, cmd_ready, busy, ira_bus_if_inst.sda_d_oe}, 5'b11100);
    end_sim();
  end
endmodule // i2c_register_access_slave_bench

// ---- ira_bus_assertions.sv ----
// concurrent checks on the two-wire link between host and device
`timescale 1ns/1ps

module ira_bus_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // host pins
  input wire logic scl_h_oe,
  input wire logic scl_h_out,
  input wire logic sda_h_oe,
  input wire logic sda_h_out,
  // device pins
  input wire logic sda_d_oe,
  input wire logic sda_d_out,
  // wired levels
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ---------------------------------------------------------
  // helpers
  // ---------------------------------------------------------
  logic [9:0] lo_cnt_r;
  logic [9:0] still_cnt_r;
  logic       sda_prev_r;
  logic       scl_prev_r;
  logic       frame_r;

  // counters saturate so a long idle never wraps into a false pass
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lo_cnt_r    <= 10'h000;
      still_cnt_r <= 10'h000;
    end else begin
      lo_cnt_r    <= scl ? 10'h000 : lo_cnt_r + {9'h000, lo_cnt_r != 10'h3ff};
      still_cnt_r <= (sda != sda_prev_r) ? 10'h000 : still_cnt_r + {9'h000, still_cnt_r != 10'h3ff};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sda_prev_r <= 1'b1;
      scl_prev_r <= 1'b1;
      frame_r    <= 1'b0;
    end else begin
      sda_prev_r <= sda;
      scl_prev_r <= scl;
      if (scl && scl_prev_r && sda_prev_r && !sda) begin
        frame_r <= 1'b1;
      end else if (scl && scl_prev_r && !sda_prev_r && sda) begin
        frame_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------
  // properties
  // ---------------------------------------------------------
  chk_pins_low: assert property (!scl_h_out && !sda_h_out && !sda_d_out)
    else $error("open-drain value not low");
  chk_wire_and: assert property (scl == !scl_h_oe && sda == !(sda_h_oe || sda_d_oe))
    else $error("wired level does not match enables");
  chk_dev_edge: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device moved sda while scl high");
  chk_ack_hold: assert property ($rose(scl) && sda_d_oe |-> sda_d_oe [*8])
    else $error("device let go of sda in high phase");
  chk_dev_frame: assert property (sda_d_oe |-> frame_r)
    else $error("device drove sda outside a frame");
  chk_start_free: assert property (scl && $past(scl) && $fell(sda) |-> !sda_d_oe)
    else $error("device held sda at a start");
  chk_data_setup: assert property ($rose(scl) |-> still_cnt_r >= 10'h019)
    else $error("sda setup before scl rise too short");
  chk_scl_low: assert property ($rose(scl) |-> lo_cnt_r >= 10'h145)
    else $error("scl low phase too short");
endmodule // ira_bus_assertions

// ---- ira_bus_if.sv ----
// open-drain two-wire bus joining host and device
`timescale 1ns/1ps
interface ira_bus_if;
  logic scl_h_oe;
  logic scl_h_out;
  logic sda_h_oe;
  logic sda_h_out;
  logic sda_d_oe;
  logic sda_d_out;
  logic scl;
  logic sda;

  // wired-AND with external pull-up
  assign scl = ~scl_h_oe;
  assign sda = ~(sda_h_oe | sda_d_oe);

  modport host (output scl_h_oe, scl_h_out, sda_h_oe, sda_h_out, input scl, sda);
  modport dev  (output sda_d_oe, sda_d_out, input scl, sda);
endinterface

// ---- ira_consts.svh ----
// constants for the two-wire register access link
`ifndef IRA_CONSTS_SVH
`define IRA_CONSTS_SVH

// ---------------------------------------------------------
// addressing
// ---------------------------------------------------------
`define IRA_ADDR_LOW   7'h40
`define IRA_ADDR_HIGH  7'h41
`define IRA_DIR_WR     1'b0
`define IRA_DIR_RD     1'b1

// ---------------------------------------------------------
// bit positions within a nine-bit byte slot
// ---------------------------------------------------------
`define IRA_BIT_LAST   4'h7
`define IRA_BIT_ACK    4'h8

// ---------------------------------------------------------
// reset values
// ---------------------------------------------------------
`define IRA_BYTE_RST   8'h00
`define IRA_CNT_RST    4'h0

// ---------------------------------------------------------
// timing
// ---------------------------------------------------------
`define IRA_CLK_MHZ    250
`define IRA_T_LOW_NS   1300
`define IRA_T_HIGH_NS  600
// quarter bit: two quarters must cover the low time, rounded up
`define IRA_QTR        ((`IRA_T_LOW_NS * `IRA_CLK_MHZ + 1999) / 2000)

`endif

// ---- ira_dev.sv ----
// register access slave clocked by the link clock
// How it works
// RL1: answer 0x40, or 0x41 when strap high
// RL2: first byte is address plus direction
// RL3: bytes are eight bits, MSB first
// RL4: receiver acknowledges in the ninth clock
// RL5: host frames every transfer with start, stop
// RL6: start and stop from SDA while SCL high
// RL7: SDA changes only while SCL low
// RL8: hold SDA low through acknowledge clock
// RL9: pins only pull low or release
// RL10: no limit on bytes per frame
// RL11: single and multi byte at any register
// RL12: reads continue through registers while acknowledged
// RL13: register byte sets start, writes increment
// RL14: write is address, register, then data
// RL15: read sets register, repeats start, reads
// RL16: host acknowledges all but last byte
// RL17: host NACKs last byte then stops
// RL18: mismatched address: stay released, wait start
// RL19: pointer survives repeated start
`timescale 1ns/1ps
`include "ira_consts.svh"

module ira_dev (
  // link
  ira_bus_if.dev          bus,
  // user side
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       io_supply_level,
  output logic            busy,
  output logic            upd_valid,
  output logic [7:0]      upd_addr,
  output logic [7:0]      upd_data
);
  import ira_pkg::*;

  // ---------------------------------------------------------
  // declarations
  // ---------------------------------------------------------
  logic [7:0]     mem [0:255];
  logic           start_tog_r;
  logic           stop_tog_r;
  logic           start_ack_r;
  logic           sel_s1_r;
  logic           sel_s2_r;
  ira_dstate_type state_r;
  ira_dstate_type state_nxt;
  logic [3:0]     cnt_r;
  logic [6:0]     sh_r;
  logic [7:0]     ptr_r;
  logic [7:0]     tx_r;
  logic           ack_r;
  logic           oe_r;
  logic           zero_r;
  logic           wr_tog_r;
  logic [7:0]     wr_addr_r;
  logic [7:0]     wr_data_r;
  logic           start_now;
  logic           last_bit;
  logic           ack_bit;
  logic           hit;
  logic [7:0]     byte_nxt;
  logic [2:0]     x_s1_r;
  logic [2:0]     x_s2_r;
  logic [2:0]     x_s3_r;
  logic [2:0]     x_edge;

  // ---------------------------------------------------------
  // start and stop detection
  // ---------------------------------------------------------
  // these flops run on SDA itself; SCL cannot see a start any other way
  always_ff @(negedge bus.sda or negedge rstn) begin
    if (!rstn) begin
      start_tog_r <= 1'b0;
    end else if (bus.scl) begin
      start_tog_r <= ~start_tog_r; // RL6
    end
  end

  always_ff @(posedge bus.sda or negedge rstn) begin
    if (!rstn) begin
      stop_tog_r <= 1'b0;
    end else if (bus.scl) begin
      stop_tog_r <= ~stop_tog_r; // RL6
    end
  end

  // ---------------------------------------------------------
  // link-side decode
  // ---------------------------------------------------------
  assign start_now = start_tog_r ^ start_ack_r;
  assign byte_nxt  = {sh_r, bus.sda}; // RL3
  assign last_bit  = (cnt_r == `IRA_BIT_LAST);
  assign ack_bit   = (cnt_r == `IRA_BIT_ACK);
  assign hit       = (byte_nxt[7:1] == (sel_s2_r ? `IRA_ADDR_HIGH : `IRA_ADDR_LOW)); // RL1

  // strap is static but still passes two flops
  always_ff @(posedge bus.scl or negedge rstn) begin
    if (!rstn) begin
      sel_s1_r <= 1'b0;
      sel_s2_r <= 1'b0;
    end else begin
      sel_s1_r <= io_supply_level;
      sel_s2_r <= sel_s1_r;
    end
  end

  // ---------------------------------------------------------
  // bit counter and shifter
  // ---------------------------------------------------------
  always_ff @(posedge bus.scl or negedge rstn) begin
    if (!rstn) begin
      cnt_r       <= `IRA_CNT_RST;
      sh_r        <= 7'h00;
      start_ack_r <= 1'b0;
    end else begin
      start_ack_r <= start_tog_r;
      sh_r        <= byte_nxt[6:0]; // RL3
      if (start_now) begin
        cnt_r <= 4'h1; // RL2
      end else if (ack_bit) begin
        cnt_r <= `IRA_CNT_RST;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------
  // frame state
  // ---------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DS_ADDR: begin
        if (last_bit) begin
          if (!hit) begin
            state_nxt = DS_IDLE; // RL18
          end else if (byte_nxt[0] == `IRA_DIR_RD) begin
            state_nxt = DS_RDATA; // RL2
          end else begin
            state_nxt = DS_REG; // RL2
          end
        end
      end
      DS_REG: begin
        if (last_bit) begin
          state_nxt = DS_WDATA; // RL13
        end
      end
      DS_RDATA: begin
        if (ack_bit && bus.sda) begin
          state_nxt = DS_IDLE; // RL12
        end
      end
      DS_WDATA: state_nxt = DS_WDATA; // RL10
      DS_IDLE:  state_nxt = DS_IDLE;
      default:  state_nxt = DS_IDLE;
    endcase
    if (start_now) begin
      state_nxt = DS_ADDR; // RL5
    end
  end

  always_ff @(posedge bus.scl or negedge rstn) begin
    if (!rstn) begin
      state_r <= DS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------
  // acknowledge decision
  // ---------------------------------------------------------
  always_ff @(posedge bus.scl or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= last_bit && !start_now &&
               ((state_r == DS_ADDR && hit) || state_r == DS_REG || state_r == DS_WDATA); // RL4 RL8 RL18
    end
  end

  // ---------------------------------------------------------
  // register pointer and read data
  // ---------------------------------------------------------
  // pointer is never cleared by a start, so a read resumes where the write left it
  always_ff @(posedge bus.scl or negedge rstn) begin
    if (!rstn) begin
      ptr_r <= `IRA_BYTE_RST;
    end else if (!start_now) begin
      if (state_r == DS_REG && last_bit) begin
        ptr_r <= byte_nxt; // RL13 RL19
      // ack_r still high marks the address acknowledge, which is not a host ack
      end else if ((state_r == DS_WDATA && last_bit) || (state_r == DS_RDATA && ack_bit && !ack_r)) begin
        ptr_r <= ptr_r + 8'h01; // RL11 RL12 RL13
      end
    end
  end

  always_ff @(posedge bus.scl or negedge rstn) begin
    if (!rstn) begin
      tx_r <= `IRA_BYTE_RST;
    end else if (state_r == DS_ADDR && last_bit) begin
      tx_r <= mem[ptr_r]; // RL12
    end else if (state_r == DS_RDATA && ack_bit && !ack_r) begin
      tx_r <= mem[ptr_r + 8'h01]; // RL12
    end
  end

  // ---------------------------------------------------------
  // register store
  // ---------------------------------------------------------
  always_ff @(posedge bus.scl) begin
    if (state_r == DS_WDATA && last_bit && !start_now) begin
      mem[ptr_r] <= byte_nxt; // RL13
    end
  end

  always_ff @(posedge bus.scl or negedge rstn) begin
    if (!rstn) begin
      wr_tog_r  <= 1'b0;
      wr_addr_r <= `IRA_BYTE_RST;
      wr_data_r <= `IRA_BYTE_RST;
    end else if (state_r == DS_WDATA && last_bit && !start_now) begin
      wr_tog_r  <= ~wr_tog_r;
      wr_addr_r <= ptr_r;
      wr_data_r <= byte_nxt;
    end
  end

  // ---------------------------------------------------------
  // SDA drive
  // ---------------------------------------------------------
  // driven on the falling edge so data never moves with SCL high
  always_ff @(negedge bus.scl or negedge rstn) begin
    if (!rstn) begin
      oe_r   <= 1'b0;
      zero_r <= 1'b0;
    end else begin
      zero_r <= 1'b0; // RL9
      if (ack_r) begin
        oe_r <= 1'b1; // RL8 RL7
      end else if (state_r == DS_RDATA && cnt_r < `IRA_BIT_ACK) begin
        oe_r <= ~tx_r[~cnt_r[2:0]]; // RL3 RL7 RL9
      end else begin
        oe_r <= 1'b0; // RL18
      end
    end
  end

  assign bus.sda_d_oe  = oe_r;
  assign bus.sda_d_out = zero_r;

  // ---------------------------------------------------------
  // crossing to the user clock
  // ---------------------------------------------------------
  // write address and data are held for a whole byte, far longer than the sync
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      x_s1_r <= 3'h0;
      x_s2_r <= 3'h0;
      x_s3_r <= 3'h0;
    end else begin
      x_s1_r <= {wr_tog_r, stop_tog_r, start_tog_r};
      x_s2_r <= x_s1_r;
      x_s3_r <= x_s2_r;
    end
  end

  assign x_edge = x_s2_r ^ x_s3_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else if (x_edge[0]) begin
      busy <= 1'b1; // RL6
    end else if (x_edge[1]) begin
      busy <= 1'b0; // RL6
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      upd_valid <= 1'b0;
      upd_addr  <= `IRA_BYTE_RST;
      upd_data  <= `IRA_BYTE_RST;
    end else begin
      upd_valid <= x_edge[2];
      if (x_edge[2]) begin
        upd_addr <= wr_addr_r;
        upd_data <= wr_data_r;
      end
    end
  end

endmodule // ira_dev

// ---- ira_host.sv ----
// bus master end: makes SCL and runs register transfers
`timescale 1ns/1ps
`include "ira_consts.svh"

module ira_host (
  // link
  ira_bus_if.host         bus,
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // command
  input  wire logic       cmd_valid,
  input  wire logic       cmd_rd,
  input  wire logic [6:0] cmd_dev,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_len,
  input  wire logic [7:0] wr_data,
  output logic            cmd_ready,
  output logic            wr_take,
  // results
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  output logic            done,
  output logic            nack
);
  import ira_pkg::*;

  // ---------------------------------------------------------
  // declarations
  // ---------------------------------------------------------
  localparam logic [7:0] QTR_LAST = 8'(`IRA_QTR - 1);

  logic [1:0]     s1_r;
  logic [1:0]     s2_r;
  logic [7:0]     qcnt_r;
  logic [1:0]     ph_r;
  logic [3:0]     bi_r;
  ira_hstate_type st_r;
  ira_kind_type   kind_r;
  logic [7:0]     tx_r;
  logic [7:0]     rx_r;
  logic [7:0]     rem_r;
  logic           rd_r;
  logic [6:0]     dev_r;
  logic [7:0]     reg_r;
  logic           ack_in_r;
  logic           scl_oe_r;
  logic           sda_oe_r;
  logic           zero_r;
  logic           tick;
  logic           step;
  logic           sending;
  logic           bit_low;

  // ---------------------------------------------------------
  // pin sync and quarter-bit timer
  // ---------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 2'b11;
      s2_r <= 2'b11;
    end else begin
      s1_r <= {bus.scl, bus.sda};
      s2_r <= s1_r;
    end
  end

  assign tick = (qcnt_r == QTR_LAST);
  assign step = tick && (ph_r == 2'h3);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      qcnt_r <= 8'h00;
      ph_r   <= 2'h0;
    end else if (st_r == HS_IDLE) begin
      qcnt_r <= 8'h00;
      ph_r   <= 2'h0;
    end else begin
      qcnt_r <= tick ? 8'h00 : qcnt_r + 8'h01;
      if (tick) begin
        ph_r <= ph_r + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------
  assign sending = !(kind_r == BK_DATA && rd_r);
  // ack every read byte but the last
  assign bit_low = (bi_r < `IRA_BIT_ACK) ? (sending && !tx_r[~bi_r[2:0]]) : (!sending && rem_r != 8'h01);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      zero_r   <= 1'b0;
    end else begin
      zero_r   <= 1'b0; // RL9
      scl_oe_r <= (st_r != HS_IDLE) && !ph_r[1];
      // SDA moves one quarter after SCL falls, never with it
      case (st_r)
        HS_START: begin
          if (ph_r == 2'h1) sda_oe_r <= 1'b0;
          if (ph_r == 2'h3) sda_oe_r <= 1'b1; // RL5 RL15
        end
        HS_STOP: begin
          if (ph_r == 2'h1) sda_oe_r <= 1'b1;
          if (ph_r == 2'h3) sda_oe_r <= 1'b0; // RL5 RL17
        end
        HS_BYTE: begin
          if (ph_r == 2'h1) sda_oe_r <= bit_low; // RL3 RL4 RL7 RL16 RL17
        end
        HS_IDLE: sda_oe_r <= 1'b0;
        default: sda_oe_r <= 1'b0;
      endcase
    end
  end

  assign bus.scl_h_oe  = scl_oe_r;
  assign bus.scl_h_out = zero_r;
  assign bus.sda_h_oe  = sda_oe_r;
  assign bus.sda_h_out = zero_r;

  // ---------------------------------------------------------
  // sampling
  // ---------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_r     <= 8'h00;
      ack_in_r <= 1'b1;
    end else if (st_r == HS_BYTE && tick && ph_r == 2'h2) begin
      if (bi_r < `IRA_BIT_ACK) begin
        rx_r <= {rx_r[6:0], s2_r[0]}; // RL3
      end else begin
        ack_in_r <= s2_r[0]; // RL4
      end
    end
  end

  // ---------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r      <= HS_IDLE;
      kind_r    <= BK_ADW;
      tx_r      <= 8'h00;
      rem_r     <= 8'h00;
      rd_r      <= 1'b0;
      dev_r     <= 7'h00;
      reg_r     <= 8'h00;
      bi_r      <= 4'h0;
      cmd_ready <= 1'b1;
      wr_take   <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= 8'h00;
      done      <= 1'b0;
      nack      <= 1'b0;
    end else begin
      wr_take  <= 1'b0;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      case (st_r)
        HS_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            st_r      <= HS_START; // RL5
            kind_r    <= BK_ADW;
            tx_r      <= {cmd_dev, `IRA_DIR_WR}; // RL2 RL14 RL15
            rem_r     <= cmd_len;
            rd_r      <= cmd_rd;
            dev_r     <= cmd_dev;
            reg_r     <= cmd_reg;
            cmd_ready <= 1'b0;
            nack      <= 1'b0;
          end
        end
        HS_START: begin
          if (step) begin
            st_r <= HS_BYTE;
            bi_r <= 4'h0;
          end
        end
        HS_STOP: begin
          if (step) begin
            st_r      <= HS_IDLE;
            done      <= 1'b1;
            cmd_ready <= 1'b1;
          end
        end
        HS_BYTE: begin
          if (step && bi_r != `IRA_BIT_ACK) begin
            bi_r <= bi_r + 4'h1;
          end else if (step) begin
            bi_r <= 4'h0;
            if (sending && ack_in_r) begin
              nack <= 1'b1;
              st_r <= HS_STOP;
            end else begin
              case (kind_r)
                BK_ADW: begin
                  kind_r <= BK_REG;
                  tx_r   <= reg_r; // RL14
                end
                BK_REG: begin
                  if (rem_r == 8'h00) begin
                    st_r <= HS_STOP;
                  end else if (rd_r) begin
                    st_r   <= HS_START; // RL15
                    kind_r <= BK_ADR;
                    tx_r   <= {dev_r, `IRA_DIR_RD}; // RL15
                  end else begin
                    kind_r  <= BK_DATA; // RL14
                    tx_r    <= wr_data;
                    wr_take <= 1'b1;
                  end
                end
                BK_ADR: kind_r <= BK_DATA;
                BK_DATA: begin
                  rem_r    <= rem_r - 8'h01;
                  rd_valid <= rd_r;
                  rd_data  <= rx_r;
                  if (rem_r == 8'h01) begin
                    st_r <= HS_STOP; // RL17
                  end else if (!rd_r) begin
                    tx_r    <= wr_data;
                    wr_take <= 1'b1;
                  end
                end
                default: st_r <= HS_STOP;
              endcase
            end
          end
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end

endmodule // ira_host

// ---- ira_pkg.sv ----
// types shared by both ends of the register access link
package ira_pkg;

  typedef enum logic [4:0] {
    DS_IDLE  = 5'b0_0001,
    DS_ADDR  = 5'b0_0010,
    DS_REG   = 5'b0_0100,
    DS_WDATA = 5'b0_1000,
    DS_RDATA = 5'b1_0000
  } ira_dstate_type;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'b0001,
    HS_START = 4'b0010,
    HS_BYTE  = 4'b0100,
    HS_STOP  = 4'b1000
  } ira_hstate_type;

  typedef enum logic [3:0] {
    BK_ADW  = 4'b0001,
    BK_REG  = 4'b0010,
    BK_ADR  = 4'b0100,
    BK_DATA = 4'b1000
  } ira_kind_type;

endpackage
